// ---- hw/serial_map.vh ----
/*
  Register offsets, field positions and reset values of the asynchronous serial
  transceiver. Assumes a 32-bit classic Wishbone slave with byte addresses.

// Notes on behaviour
// - transmit pin held high when enabled and idle; released to port when disabled.
// - frame is one start bit, 8 or 9 data bits LSB first, one stop bit.
// - start bit drives the pin low, stop bit drives it high.
// - idle character is 10 high bit times (8-bit) or 11 (9-bit).
// - break is a frame-length run of low bits followed by one high bit.
// - breaks repeat while send-break is set; one high bit follows the last.
// - in 9-bit mode the ninth transmitted bit comes from the tx ninth-bit field.
// - enabling the transmitter first sends a 10 or 11 bit preamble of ones.
// - re-enabling mid-word sends preamble after the word, skips stop, drops buffered data.
// - tx empty and tx done clear on status read then data write.
// - data written while shifting waits in the holding buffer until the frame ends.
// - data written while idle loads the shifter, starts, and leaves tx empty set.
// - tx empty requests interrupt when enabled and both cpu mask bits are clear.
// - tx done sets after a stop bit or a break; interrupts when enabled.
// - receive enable starts the start-bit hunt; bits arrive LSB first.
// - in 9-bit mode the received ninth bit goes to the rx ninth-bit field.
// - completed character moves to rx holding buffer, sets rx full, may interrupt.
// - rx full clears on status read then data read.
// - idle line detection sets the idle flag and may interrupt.
// - character arriving while rx full sets overrun and keeps the old buffer.
// - overrun clears on status read then data read.
// - noise flag sets with rx full, no own interrupt, clears like rx full.
*/
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH

`define OFS_STATUS   8'h00
`define OFS_DATA     8'h04
`define OFS_CTRL1    8'h08
`define OFS_CTRL2    8'h0C
`define OFS_BAUD     8'h10

`define ST_TXEMPTY   7
`define ST_TXDONE    6
`define ST_RXFULL    5
`define ST_IDLE      4
`define ST_OVRN      3
`define ST_NOISE     2

`define C1_RXB9      7
`define C1_TXB9      6
`define C1_M         4

`define C2_TXE_IE    7
`define C2_TXD_IE    6
`define C2_RX_IE     5
`define C2_IDL_IE    4
`define C2_TXEN      3
`define C2_RXEN      2
`define C2_BRK       0

`define CTRL1_RST    8'h00
`define CTRL2_RST    8'h00
`define BAUD_RST     8'h14
`define BITS_8       4'hA
`define BITS_9       4'hB
`define OS_LAST      4'hF

`endif

// ---- hw/serial_xcvr.v ----
/*
  Full-duplex asynchronous serial transceiver with a classic Wishbone register
  slave, 16x oversampled receiver and holding buffers in both directions.
  Assumes I_CPU_IMASK comes from cpu logic on I_MCLK and I_RXD from a pin.
*/
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_map.vh"

module serial_xcvr (
  input  wire        I_MCLK,      // system clock, 40 MHz
  input  wire        I_RST_N,     // synchronous reset, active low
  input  wire        I_WB_CYC,    // wishbone cycle
  input  wire        I_WB_STB,    // wishbone strobe
  input  wire        I_WB_WE,     // wishbone write enable
  input  wire [7:0]  I_WB_ADR,    // wishbone byte address
  input  wire [3:0]  I_WB_SEL,    // wishbone byte selects
  input  wire [31:0] I_WB_DAT,    // wishbone write data
  output reg  [31:0] O_WB_DAT,    // wishbone read data
  output reg         O_WB_ACK,    // wishbone acknowledge
  input  wire [1:0]  I_CPU_IMASK, // cpu interrupt mask bits
  input  wire        I_RXD,       // serial receive pin
  output reg         O_TXD,       // serial transmit pin level
  output reg         O_TXD_OE,    // transmit pin driven by this block
  output reg         O_IRQ        // interrupt request
);

  localparam [4:0] TX_IDLE = 5'h01;
  localparam [4:0] TX_PRE  = 5'h02;
  localparam [4:0] TX_CHR  = 5'h04;
  localparam [4:0] TX_BRK  = 5'h08;
  localparam [4:0] TX_MARK = 5'h10;
  // the mark state exists only to close a break run;
  // without it a start bit right after a break
  // would be lost in the low level before it
  // and the far end could not find the frame

  function sel_reg;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      sel_reg = (adr == ofs);
    end
  endfunction

  // builds a padded frame, start bit in bit 0;
  // unused top bits stay high so surplus shifts
  // after the stop bit keep the line at mark
  function [11:0] frame_word;
    input       nine;
    input       b9;
    input [7:0] data;
    begin
      if (nine)
        frame_word = {2'b11, b9, data, 1'b0};
      else
        frame_word = {3'b111, data, 1'b0};
    end
  endfunction

  reg  [7:0]  ctrl1_r;
  reg  [7:0]  ctrl2_r;
  reg  [7:0]  baud_r;
  reg  [7:0]  div_r;
  reg         tick_r;
  reg         sr_arm_r;
  reg         tx_buf_empty_flag_r;
  reg         tc_r;
  reg         rx_buf_full_flag_r;
  reg         idle_r;
  reg         or_r;
  reg         nf_r;
  reg  [7:0]  tdr_r;
  reg         tdr_t8_r;
  reg         tdr_full_r;
  reg  [7:0]  rdr_r;
  reg         r8_r;
  reg  [4:0]  tx_st_r;
  reg  [11:0] tx_sh_r;
  reg  [3:0]  tx_cnt_r;
  reg  [3:0]  tx_ph_r;
  reg         te_prev_r;
  reg         pend_pre_r;
  reg         rx_m_r;
  reg         rx_s_r;
  reg         rx_act_r;
  reg  [3:0]  rx_ph_r;
  reg  [3:0]  rx_bit_r;
  reg  [2:0]  rx_smp_r;
  reg         rx_noise_r;
  reg  [8:0]  rx_sh_r;
  reg  [7:0]  idle_cnt_r;
  reg         idle_arm_r;

  wire        mode9    = ctrl1_r[`C1_M];
  wire [3:0]  nbits    = mode9 ? `BITS_9 : `BITS_8;
  // control bits are plain levels; software owns them
  // and hardware never writes them back,
  // so no set and clear can collide here
  wire        te       = ctrl2_r[`C2_TXEN];
  wire        re       = ctrl2_r[`C2_RXEN];
  wire        send_break_ctl      = ctrl2_r[`C2_BRK];
  wire        acc      = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire        wr       = acc & I_WB_WE & I_WB_SEL[0];
  wire        rd       = acc & ~I_WB_WE;
  wire        st_rd    = rd & sel_reg(I_WB_ADR, `OFS_STATUS);
  wire        dat_rd   = rd & sel_reg(I_WB_ADR, `OFS_DATA);
  wire        dat_wr   = wr & sel_reg(I_WB_ADR, `OFS_DATA);
  wire        seq_wr   = dat_wr & sr_arm_r;
  wire        seq_rd   = dat_rd & sr_arm_r;
  wire        bit_tick = tick_r & (tx_ph_r == `OS_LAST);
  wire        te_rise  = te & ~te_prev_r;
  // a word cut short before its stop bit when the preamble is pending
  wire        tx_cut   = (tx_st_r == TX_CHR) & pend_pre_r & (tx_cnt_r == 4'h2);
  wire        tx_end   = (tx_st_r == TX_IDLE) | (tx_cnt_r == 4'h1) | tx_cut;
  wire        direct   = dat_wr & (tx_st_r == TX_IDLE) & te & ~pend_pre_r & ~send_break_ctl;
  wire [11:0] chr_frm  = frame_word(mode9, tdr_t8_r, tdr_r);
  wire [11:0] dir_frm  = frame_word(mode9, ctrl1_r[`C1_TXB9], I_WB_DAT[7:0]);
  wire        rx_maj   = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[0] & rx_smp_r[2]) |
                         (rx_smp_r[1] & rx_smp_r[2]);
  wire        rx_eval  = tick_r & rx_act_r & (rx_ph_r == `OS_LAST);
  wire        rx_done  = rx_eval & (rx_bit_r == nbits - 4'h1);
  wire        rx_nz    = rx_noise_r | ~(&rx_smp_r | ~|rx_smp_r);
  wire        idle_hit = tick_r & ~rx_act_r & re & idle_arm_r & rx_s_r &
                         (idle_cnt_r == {nbits, 4'h0} - 8'h01);
  wire        cpu_ok   = (I_CPU_IMASK == 2'b00);

  // oversampling tick, 16 per bit time
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else if (div_r >= baud_r) begin
      div_r  <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // register slave: one wait state, ack for exactly one cycle
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
      ctrl1_r  <= `CTRL1_RST;
      ctrl2_r  <= `CTRL2_RST;
      baud_r   <= `BAUD_RST;
      sr_arm_r <= 1'b0;
    end else begin
      O_WB_ACK <= acc;
      if (rd) begin
        case (I_WB_ADR)
          `OFS_STATUS: O_WB_DAT <= {24'h000000, tx_buf_empty_flag_r, tc_r, rx_buf_full_flag_r, idle_r, or_r, nf_r, 2'b00};
          `OFS_DATA:   O_WB_DAT <= {24'h000000, rdr_r};
          `OFS_CTRL1:  O_WB_DAT <= {24'h000000, r8_r, ctrl1_r[6:0]};
          `OFS_CTRL2:  O_WB_DAT <= {24'h000000, ctrl2_r};
          `OFS_BAUD:   O_WB_DAT <= {24'h000000, baud_r};
          default:     O_WB_DAT <= 32'h00000000;
        endcase
      end
      if (wr & sel_reg(I_WB_ADR, `OFS_CTRL1))
        ctrl1_r <= {1'b0, I_WB_DAT[6:0]};
      if (wr & sel_reg(I_WB_ADR, `OFS_CTRL2))
        ctrl2_r <= I_WB_DAT[7:0];
      if (wr & sel_reg(I_WB_ADR, `OFS_BAUD))
        baud_r <= I_WB_DAT[7:0];
      // status read arms the clear; the following data access consumes it
      if (st_rd)
        sr_arm_r <= 1'b1;
      else if (dat_rd | dat_wr)
        sr_arm_r <= 1'b0;
    end
  end

  // transmitter
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tx_st_r    <= TX_IDLE;
      tx_sh_r    <= 12'hFFF;
      tx_cnt_r   <= 4'h0;
      tx_ph_r    <= 4'h0;
      te_prev_r  <= 1'b0;
      pend_pre_r <= 1'b0;
      tdr_r      <= 8'h00;
      tdr_t8_r   <= 1'b0;
      tdr_full_r <= 1'b0;
      tx_buf_empty_flag_r     <= 1'b1;
      tc_r       <= 1'b1;
      O_TXD      <= 1'b1;
      O_TXD_OE   <= 1'b0;
    end else begin
      te_prev_r <= te;
      O_TXD_OE  <= te;
      O_TXD     <= (tx_st_r == TX_IDLE) ? 1'b1 : tx_sh_r[0];
      if (tick_r)
        tx_ph_r <= tx_ph_r + 4'h1;
      if (seq_wr) begin
        tx_buf_empty_flag_r <= 1'b0;
        tc_r   <= 1'b0;
      end
      if (dat_wr & ~direct) begin
        tdr_r      <= I_WB_DAT[7:0];
        // ninth bit latched with the data, so a later change
        // of the control bit cannot reach a queued word
        tdr_t8_r   <= ctrl1_r[`C1_TXB9];
        tdr_full_r <= 1'b1;
      end
      if (te_rise) begin
        pend_pre_r <= 1'b1;
        if (tx_st_r != TX_IDLE)
          tdr_full_r <= 1'b0;
      end
      if (bit_tick) begin
        if (!tx_end) begin
          tx_sh_r  <= {1'b1, tx_sh_r[11:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
        end else begin
          // event wins over a clear in the same cycle
          if ((tx_st_r == TX_CHR && !tx_cut) || tx_st_r == TX_BRK)
            tc_r <= 1'b1;
          if (te && pend_pre_r) begin
            tx_st_r    <= TX_PRE;
            tx_sh_r    <= 12'hFFF;
            tx_cnt_r   <= nbits;
            pend_pre_r <= te_rise;
          end else if (te && send_break_ctl) begin
            tx_st_r  <= TX_BRK;
            tx_sh_r  <= 12'h000;
            tx_cnt_r <= nbits;
          end else if (tx_st_r == TX_BRK) begin
            tx_st_r  <= TX_MARK;
            tx_sh_r  <= 12'hFFF;
            tx_cnt_r <= 4'h1;
          end else if (te && tdr_full_r && !(seq_wr && !dat_wr)) begin
            tx_st_r    <= TX_CHR;
            tx_sh_r    <= chr_frm;
            tx_cnt_r   <= nbits;
            tdr_full_r <= dat_wr & ~direct;
            tx_buf_empty_flag_r     <= 1'b1;
          end else begin
            tx_st_r  <= TX_IDLE;
            tx_cnt_r <= 4'h0;
          end
        end
      end
      if (direct) begin
        tx_st_r  <= TX_CHR;
        tx_sh_r  <= dir_frm;
        tx_cnt_r <= nbits;
        tx_ph_r  <= 4'h0;
        tx_buf_empty_flag_r   <= 1'b1;
      end
    end
  end

  // receiver: two-stage synchroniser, then 16x majority sampling
  // only the second stage is read; the first may be metastable
  // stop level is not checked, framing errors are not reported
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      rx_m_r     <= 1'b1;
      rx_s_r     <= 1'b1;
      rx_act_r   <= 1'b0;
      rx_ph_r    <= 4'h0;
      rx_bit_r   <= 4'h0;
      rx_smp_r   <= 3'h7;
      rx_noise_r <= 1'b0;
      rx_sh_r    <= 9'h000;
      rdr_r      <= 8'h00;
      r8_r       <= 1'b0;
      rx_buf_full_flag_r     <= 1'b0;
      or_r       <= 1'b0;
      nf_r       <= 1'b0;
      idle_r     <= 1'b0;
      idle_cnt_r <= 8'h00;
      idle_arm_r <= 1'b0;
    end else begin
      rx_m_r <= I_RXD;
      rx_s_r <= rx_m_r;
      if (seq_rd) begin
        rx_buf_full_flag_r <= 1'b0;
        or_r   <= 1'b0;
        nf_r   <= 1'b0;
        idle_r <= 1'b0;
      end
      if (!re) begin
        rx_act_r <= 1'b0;
      end else if (tick_r && !rx_act_r && !rx_s_r) begin
        rx_act_r   <= 1'b1;
        rx_ph_r    <= 4'h0;
        rx_bit_r   <= 4'h0;
        rx_noise_r <= 1'b0;
      end else if (tick_r && rx_act_r) begin
        rx_ph_r <= rx_ph_r + 4'h1;
        if (rx_ph_r >= 4'h7 && rx_ph_r <= 4'h9)
          rx_smp_r <= {rx_s_r, rx_smp_r[2:1]};
        if (rx_eval) begin
          rx_bit_r   <= rx_bit_r + 4'h1;
          rx_noise_r <= rx_nz;
          if (rx_bit_r == 4'h0 && rx_maj)
            rx_act_r <= 1'b0;                            // false start
          else if (rx_done)
            rx_act_r <= 1'b0;
          else if (rx_bit_r != 4'h0)
            rx_sh_r <= {rx_maj, rx_sh_r[8:1]};
        end
      end
      if (rx_done) begin
        idle_arm_r <= 1'b1;
        if (rx_buf_full_flag_r && !seq_rd) begin
          or_r <= 1'b1;
        end else begin
          rdr_r  <= mode9 ? rx_sh_r[7:0] : rx_sh_r[8:1];
          r8_r   <= mode9 & rx_sh_r[8];
          rx_buf_full_flag_r <= 1'b1;
          nf_r   <= rx_nz;
        end
      end
      // idle counts high oversample ticks after a character
      if (rx_act_r || !rx_s_r || !re)
        idle_cnt_r <= 8'h00;
      else if (tick_r && idle_arm_r)
        idle_cnt_r <= idle_cnt_r + 8'h01;
      if (idle_hit) begin
        idle_r     <= 1'b1;
        idle_arm_r <= 1'b0;
      end
    end
  end

  // single request line gated by the cpu mask
  always @(posedge I_MCLK) begin
    if (!I_RST_N)
      O_IRQ <= 1'b0;
    else
      // registered for a clean output; costs one cycle of latency
      // noise has no enable of its own, it rides on rx full
      // overrun shares the rx enable
      O_IRQ <= cpu_ok & ((tx_buf_empty_flag_r & ctrl2_r[`C2_TXE_IE]) |
                         (tc_r & ctrl2_r[`C2_TXD_IE]) |
                         ((rx_buf_full_flag_r | or_r) & ctrl2_r[`C2_RX_IE]) |
                         (idle_r & ctrl2_r[`C2_IDL_IE]));
  end

endmodule

// ---- verif/serial_xcvr_checker.sv ----
/*
  Port-level assertions for serial_xcvr, bound to every instance.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module serial_xcvr_checker (
  input wire        I_MCLK,      // clock
  input wire        I_RST_N,     // reset, active low
  input wire        I_WB_CYC,    // cycle
  input wire        I_WB_STB,    // strobe
  input wire        I_WB_WE,     // write enable
  input wire [7:0]  I_WB_ADR,    // address
  input wire [3:0]  I_WB_SEL,    // selects
  input wire [31:0] I_WB_DAT,    // write data
  input wire [31:0] O_WB_DAT,    // read data
  input wire        O_WB_ACK,    // acknowledge
  input wire [1:0]  I_CPU_IMASK, // cpu mask
  input wire        I_RXD,       // serial in
  input wire        O_TXD,       // serial out
  input wire        O_TXD_OE,    // out enable
  input wire        O_IRQ        // interrupt
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  wire req = I_WB_CYC && I_WB_STB && !O_WB_ACK;

  a_ack_pulse:
    assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held too long");
  a_ack_next:
    assert property (req |=> O_WB_ACK) else $error("ack missing");
  a_unmapped_zero:
    assert property (req && !I_WB_WE && I_WB_ADR > 8'h10 |=> O_WB_DAT == 32'h0) else $error("unmapped data");
  a_rdata_hold:
    assert property ($changed(O_WB_DAT) |-> O_WB_ACK && !$past(I_WB_WE)) else $error("read data moved");
  a_start_low:
    assert property ($fell(O_TXD) && O_TXD_OE |-> (!O_TXD || !O_TXD_OE)[*8]) else $error("short low bit");
  a_bit_high:
    assert property ($rose(O_TXD) && O_TXD_OE |-> (O_TXD || !O_TXD_OE)[*8]) else $error("short high bit");
  a_irq_mask:
    assert property (|I_CPU_IMASK |=> !O_IRQ) else $error("masked irq");
  a_preamble_ones:
    assert property ($rose(O_TXD_OE) && O_TXD |-> O_TXD[*8]) else $error("preamble broken");

  cover property (O_WB_ACK && $past(!I_WB_WE));
  cover property ($fell(O_TXD) && O_TXD_OE);
  cover property (O_IRQ);
endmodule

bind serial_xcvr serial_xcvr_checker chk_i (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_CPU_IMASK(I_CPU_IMASK), .I_RXD(I_RXD), .O_TXD(O_TXD),
  .O_TXD_OE(O_TXD_OE), .O_IRQ(O_IRQ));

// ---- verif/remote_peer.sv ----
/*
  Remote serial device: sends frames on demand, decodes transmitted frames.
  Assumes a divider of 0, so one bit lasts 16 clocks.
*/
`timescale 1ns/1ps
module remote_peer (
  input  wire logic clk, // bench clock
  input  wire logic txd, // line from transceiver
  input  wire logic oe,  // transceiver drives line
  input  wire logic m9,  // nine-bit words
  output logic      rxd  // line to transceiver
);
  localparam int BT = 16;
  logic [9:0] got[$];
  logic [9:0] w;
  initial rxd = 1'b1; // idle line stays high

  task send(input logic [8:0] v);
    rxd <= 1'b0;
    repeat (BT) @(posedge clk);
    for (int i = 0; i < (m9 ? 9 : 8); i++) begin
      rxd <= v[i];
      repeat (BT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BT) @(posedge clk);
  endtask

  // sample mid-bit; stop level lands in bit 9
  initial forever begin
    @(posedge clk);
    if (oe && !txd) begin
      w = 10'h0;
      repeat (BT / 2) @(posedge clk);
      for (int i = 0; i < (m9 ? 9 : 8); i++) begin
        repeat (BT) @(posedge clk);
        w[i] = txd;
      end
      repeat (BT) @(posedge clk);
      w[9] = txd;
      got.push_back(w);
    end
  end
endmodule

// ---- verif/serial_xcvr_test.sv ----
/*
  Self-checking bench for serial_xcvr: register bus, transmit and receive.
  Assumes remote_peer on the serial side and the bound checker.
*/
`timescale 1ns/1ps
`include "serial_map.vh"
module serial_xcvr_test;
  logic        clk, rst_n, cyc, stb, we, ack, txd, oe, irq, rxd, m9;
  logic [7:0]  adr, q, d, d2;
  logic [31:0] wdat, rdat;
  logic [1:0]  imask;
  logic [9:0]  exq[$];
  int          failures, n_checks, cyc_n;
  int          seed = 32'h9cabf727;

  serial_xcvr DUT (.I_MCLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'h1), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_CPU_IMASK(imask), .I_RXD(rxd), .O_TXD(txd), .O_TXD_OE(oe), .O_IRQ(irq));
  remote_peer P (.clk(clk), .txd(txd), .oe(oe), .m9(m9), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      complete_run;
    end
  end

  task chk(input logic [9:0] g, input logic [9:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, v};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  // bounded status poll until any bit of m is set
  task poll(input logic [7:0] m);
    logic [7:0] s;
    s = 8'h0;
    for (int k = 0; k < 400 && (s & m) == 8'h0; k++) wb(0, `OFS_STATUS, 8'h0, s);
    chk({2'b0, s & m}, {2'b0, m});
  endtask

  initial begin
    rst_n = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; imask = 2'b11; m9 = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, `OFS_STATUS, 8'h0, q); chk({2'b0, q}, 10'h0C0);
    wb(0, 8'h14, 8'h0, q); chk({2'b0, q}, 10'h000);
    wb(1, `OFS_BAUD, 8'h00, q);
    wb(1, `OFS_CTRL2, 8'h0C, q);
    repeat (220) @(posedge clk); // ten-bit preamble must end first
    d = $random(seed); exq.push_back({2'b10, d});
    wb(1, `OFS_DATA, d, q);
    wb(0, `OFS_STATUS, 8'h0, q); chk({9'h0, q[`ST_TXEMPTY]}, 10'h1);
    d = $random(seed); exq.push_back({2'b10, d});
    wb(1, `OFS_DATA, d, q);
    wb(0, `OFS_STATUS, 8'h0, q); chk({9'h0, q[`ST_TXEMPTY]}, 10'h0);
    poll(8'h40);
    repeat (400) @(posedge clk);
    m9 <= 1'b1;
    wb(1, `OFS_CTRL1, 8'h50, q);
    d = $random(seed); exq.push_back({2'b11, d});
    wb(1, `OFS_DATA, d, q);
    poll(8'h40);
    repeat (40) @(posedge clk);
    chk(10'(P.got.size()), 10'(exq.size()));
    foreach (exq[i]) chk(P.got[i], exq[i]);
    wb(1, `OFS_CTRL2, 8'h0D, q);
    repeat (40) @(posedge clk);
    chk({9'h0, txd}, 10'h0);
    wb(1, `OFS_CTRL2, 8'h0C, q);
    repeat (220) @(posedge clk);
    chk({9'h0, txd}, 10'h1);
    m9 <= 1'b0;
    wb(1, `OFS_CTRL1, 8'h00, q);
    wb(1, `OFS_CTRL2, 8'h2C, q);
    d = $random(seed);
    P.send({1'b0, d});
    poll(8'h20);
    chk({9'h0, irq}, 10'h0);
    imask <= 2'b00;
    repeat (3) @(posedge clk);
    chk({9'h0, irq}, 10'h1);
    imask <= 2'b11;
    wb(0, `OFS_DATA, 8'h0, q); chk({2'b0, q}, {2'b0, d});
    wb(0, `OFS_STATUS, 8'h0, q); chk({9'h0, q[`ST_RXFULL]}, 10'h0);
    d = $random(seed);
    d2 = $random(seed);
    P.send({1'b0, d});
    P.send({1'b0, d2});
    poll(8'h08);
    wb(0, `OFS_DATA, 8'h0, q); chk({2'b0, q}, {2'b0, d});
    wb(0, `OFS_STATUS, 8'h0, q); chk({2'b0, q & 8'h28}, 10'h0);
    m9 <= 1'b1;
    wb(1, `OFS_CTRL1, 8'h10, q);
    d = $random(seed);
    P.send({1'b1, d});
    poll(8'h20);
    wb(0, `OFS_CTRL1, 8'h0, q); chk({9'h0, q[`C1_RXB9]}, 10'h1);
    wb(0, `OFS_DATA, 8'h0, q); chk({2'b0, q}, {2'b0, d});
    poll(8'h10);
    complete_run;
  end
endmodule
